// *** mite_core.sv ***
`timescale 1ns/1ps
// Behaviour
// - Instruction cycle is four clock periods; execution advances once each.
// - Most instructions one cycle; branch, call and table read take two.
// - Jump, call, subroutine exit and interrupt exit take one extra cycle.
// - Writing the PC low byte jumps there, costing one extra cycle.
// - Skip tests take one cycle, one more when the skip is taken.
// - Moves: memory to working, working to memory, constant to working.
// - Carry on add above 255; borrow on subtract below 0 via carry.
// - Increment and decrement change operand by one, to memory or working.
// - AND, OR, XOR and invert set zero flag on zero result.
// - Rotates shift one bit; through-carry forms move outgoing bit to carry.
// - Call saves the following address; exit resumes at it.
// - Jump loads the target and saves no return address.
// - Skips test a byte or one bit, then continue or bypass next.
// - Bit set and clear read, change one bit, write back.
// - Table read fetches program memory constants into data memory.
// - Halt instruction puts the core into power-down.
// - Add and subtract update Z, C, AC, OV; carry forms use carry.
module mite_core (
  // Clock, reset and enable
  input  wire logic                      ref_clk_in,
  input  wire logic                      sys_rst_in,
  input  wire logic                      clk_en_in,
  // Program memory
  input  wire logic [mite_pkg::IW-1:0]   prog_data_in,
  output logic      [mite_pkg::PC_W-1:0] prog_addr_out,
  // Data memory
  input  wire logic [mite_pkg::DW-1:0]   data_rd_in,
  output logic      [mite_pkg::DA_W-1:0] data_addr_out,
  output logic      [mite_pkg::DW-1:0]   data_wr_out,
  output logic                           data_we_out,
  // Power-down
  input  wire logic                      wake_in,
  output logic                           power_down_out,
  // Core state
  output logic                           cycle_start_out,
  output logic      [mite_pkg::DW-1:0]   working_out,
  output logic      [3:0]                flags_out,
  output logic      [mite_pkg::DW-1:0]   table_high_out
);

  // ********************************************************************
  // Declarations
  // ********************************************************************
  logic [mite_pkg::PH_W-1:0] phase_q;
  mite_pkg::mite_cyc_t       cyc_q;
  logic [mite_pkg::IW-1:0]   ir_q;
  logic [mite_pkg::PC_W-1:0] pc_q;
  logic [mite_pkg::PC_W-1:0] pc_cur;
  logic [mite_pkg::PC_W-1:0] stack_q [mite_pkg::SD];
  logic [mite_pkg::SP_W-1:0] sp_q;
  logic [mite_pkg::SP_W-1:0] sp_top;
  logic [mite_pkg::DW-1:0]   working_q;
  logic [mite_pkg::DW-1:0]   mdat_q;
  logic [mite_pkg::DW-1:0]   tbl_hi_q;
  logic [3:0]                flags_q;
  logic                      halt_q;
  logic                      wake_s1_q;
  logic                      wake_s2_q;
  logic                      start_q;
  logic [mite_pkg::DA_W-1:0] dm_addr_q;
  logic [mite_pkg::DA_W-1:0] tab_m_q;
  logic [mite_pkg::DW-1:0]   dm_wdata_q;
  logic                      dm_we_q;
  logic [mite_pkg::PC_W-1:0] pm_addr_q;
  logic                      tick;
  logic                      ph_end;
  logic                      commit;
  logic                      is_ctl;
  logic                      dst_mem;
  logic                      src_imm;
  logic [3:0]                fn;
  logic [2:0]                kind;
  logic [1:0]                sub;
  logic [2:0]                bidx;
  logic [mite_pkg::DA_W-1:0] m_addr;
  logic [mite_pkg::DW-1:0]   imm;
  logic [mite_pkg::DW-1:0]   bitv;
  logic [mite_pkg::DW-1:0]   wdata;
  logic [mite_pkg::PC_W-1:0] jtarget;
  logic                      wr_mem;
  logic                      wr_work;
  logic                      skip;
  logic                      jump;
  logic                      push;
  logic                      pop;
  logic                      halt_go;
  logic                      tab_go;

  mite_alu_if alu_bus ();

  mite_alu u_alu (
    .bus (alu_bus)
  );

  // ********************************************************************
  // Decode
  // ********************************************************************
  assign is_ctl  = ir_q[mite_pkg::B_CTL];
  assign dst_mem = ir_q[mite_pkg::B_DST];
  assign src_imm = ir_q[mite_pkg::B_IMM];
  assign fn      = ir_q[12:9];
  assign kind    = ir_q[14:12];
  assign sub     = ir_q[11:10];
  assign bidx    = ir_q[9:7];
  assign m_addr  = ir_q[6:0];
  assign imm     = ir_q[7:0];
  assign pc_cur  = pc_q - 1'b1;
  assign sp_top  = sp_q - 1'b1;
  assign tick    = clk_en_in && !halt_q;
  assign ph_end  = (phase_q == mite_pkg::PH_LAST);
  assign commit  = tick && ph_end && (cyc_q == mite_pkg::CY_EXEC);

  // ********************************************************************
  // Execute
  // ********************************************************************
  always_comb begin
    alu_bus.func = fn;
    alu_bus.a    = working_q;
    alu_bus.b    = (!is_ctl && src_imm) ? imm : mdat_q;
    alu_bus.cin  = flags_q[mite_pkg::F_C];
    bitv         = mdat_q;
    bitv[bidx]   = (sub == mite_pkg::BO_SET);
    wdata        = alu_bus.res;
    jtarget      = ir_q[mite_pkg::PC_W-1:0];
    wr_mem       = 1'b0;
    wr_work      = 1'b0;
    skip         = 1'b0;
    jump         = 1'b0;
    push         = 1'b0;
    pop          = 1'b0;
    halt_go      = 1'b0;
    tab_go       = 1'b0;
    if (!is_ctl) begin
      wr_mem  = dst_mem;
      wr_work = !dst_mem;
    end else begin
      unique case (kind)
        mite_pkg::K_JUMP: jump = 1'b1;
        mite_pkg::K_CALL: begin
          jump = 1'b1;
          push = 1'b1;
        end
        mite_pkg::K_SEXIT, mite_pkg::K_IEXIT: begin
          jump    = 1'b1;
          pop     = 1'b1;
          jtarget = stack_q[sp_top];
        end
        mite_pkg::K_BIT: begin
          unique case (sub)
            mite_pkg::BO_CLR, mite_pkg::BO_SET: begin
              wr_mem = 1'b1;
              wdata  = bitv;
            end
            mite_pkg::BO_SZ:  skip = !mdat_q[bidx];
            mite_pkg::BO_SNZ: skip = mdat_q[bidx];
          endcase
        end
        mite_pkg::K_SKZ: begin
          unique case (sub)
            mite_pkg::SK_IZ: alu_bus.func = mite_pkg::FN_ADD1;
            mite_pkg::SK_DZ: alu_bus.func = mite_pkg::FN_SUB1;
            default:         alu_bus.func = mite_pkg::FN_PASB;
          endcase
          skip    = alu_bus.z;
          wr_work = ir_q[mite_pkg::B_TOW];
          wr_mem  = !ir_q[mite_pkg::B_TOW] && (sub != mite_pkg::SK_Z);
        end
        mite_pkg::K_TAB:  tab_go = 1'b1;
        mite_pkg::K_HALT: halt_go = 1'b1;
      endcase
    end
    if (wr_mem && (m_addr == mite_pkg::PC_LOW_ADDR)) begin
      jump    = 1'b1;
      jtarget = {pc_cur[mite_pkg::PC_W-1:8], wdata};
      wr_mem  = 1'b0;
    end
  end

  // ********************************************************************
  // Cycle phase
  // ********************************************************************
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      phase_q <= mite_pkg::PH_ADDR;
    end else if (tick) begin
      phase_q <= ph_end ? mite_pkg::PH_ADDR : phase_q + 1'b1;
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      start_q <= 1'b0;
    end else if (clk_en_in) begin
      start_q <= halt_q ? wake_s2_q : ph_end && !(commit && halt_go);
    end
  end

  // ********************************************************************
  // Sequencing
  // ********************************************************************
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      cyc_q <= mite_pkg::CY_BUBBLE;
      pc_q  <= mite_pkg::PC_RST;
      ir_q  <= '0;
    end else if (tick && ph_end) begin
      unique case (cyc_q)
        mite_pkg::CY_EXEC: begin
          ir_q <= prog_data_in;
          if (jump) begin
            pc_q  <= jtarget;
            cyc_q <= mite_pkg::CY_BUBBLE;
          end else begin
            pc_q <= pc_q + 1'b1;
            if (skip) begin
              cyc_q <= mite_pkg::CY_BUBBLE;
            end else if (tab_go) begin
              cyc_q <= mite_pkg::CY_TABLE;
            end else begin
              cyc_q <= mite_pkg::CY_EXEC;
            end
          end
        end
        mite_pkg::CY_BUBBLE: begin
          ir_q  <= prog_data_in;
          pc_q  <= pc_q + 1'b1;
          cyc_q <= mite_pkg::CY_EXEC;
        end
        mite_pkg::CY_TABLE: cyc_q <= mite_pkg::CY_EXEC;
        default: cyc_q <= mite_pkg::CY_EXEC;
      endcase
    end
  end

  // ********************************************************************
  // Working register and flags
  // ********************************************************************
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      working_q <= mite_pkg::WORK_RST;
    end else if (commit && wr_work) begin
      working_q <= wdata;
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      flags_q <= mite_pkg::FLAGS_RST;
    end else if (commit && !is_ctl) begin
      if (alu_bus.upd_z) begin
        flags_q[mite_pkg::F_Z] <= alu_bus.z;
      end
      if (alu_bus.upd_c) begin
        flags_q[mite_pkg::F_C] <= alu_bus.c;
      end
      if (alu_bus.upd_acov) begin
        flags_q[mite_pkg::F_AC] <= alu_bus.ac;
        flags_q[mite_pkg::F_OV] <= alu_bus.ov;
      end
    end
  end

  // ********************************************************************
  // Return address stack
  // ********************************************************************
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      sp_q <= '0;
      for (int i = 0; i < mite_pkg::SD; i++) begin
        stack_q[i] <= mite_pkg::PC_RST;
      end
    end else if (commit && push) begin
      stack_q[sp_q] <= pc_q;
      sp_q          <= sp_q + 1'b1;
    end else if (commit && pop) begin
      sp_q <= sp_top;
    end
  end

  // ********************************************************************
  // Power-down
  // ********************************************************************
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      wake_s1_q <= 1'b0;
      wake_s2_q <= 1'b0;
    end else if (clk_en_in) begin
      wake_s1_q <= wake_in;
      wake_s2_q <= wake_s1_q;
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      halt_q <= 1'b0;
    end else if (clk_en_in) begin
      if (halt_q && wake_s2_q) begin
        halt_q <= 1'b0;
      end else if (commit && halt_go) begin
        halt_q <= 1'b1;
      end
    end
  end

  // ********************************************************************
  // Memory ports
  // ********************************************************************
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      pm_addr_q <= mite_pkg::PC_RST;
      dm_addr_q <= '0;
    end else if (tick && (phase_q == mite_pkg::PH_ADDR)) begin
      if (cyc_q == mite_pkg::CY_TABLE) begin
        pm_addr_q <= {mite_pkg::TBL_PAGE, working_q};
        dm_addr_q <= tab_m_q;
      end else begin
        pm_addr_q <= pc_q;
        dm_addr_q <= m_addr;
      end
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      mdat_q <= '0;
    end else if (tick && (phase_q == mite_pkg::PH_READ)) begin
      if (m_addr == mite_pkg::PC_LOW_ADDR) begin
        mdat_q <= pc_cur[7:0];
      end else begin
        mdat_q <= data_rd_in;
      end
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      tab_m_q  <= '0;
      tbl_hi_q <= '0;
    end else if (commit && tab_go) begin
      tab_m_q <= m_addr;
    end else if (tick && ph_end && (cyc_q == mite_pkg::CY_TABLE)) begin
      tbl_hi_q <= prog_data_in[15:8];
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      dm_we_q    <= 1'b0;
      dm_wdata_q <= '0;
    end else if (tick) begin
      dm_we_q <= ph_end && ((commit && wr_mem) ||
                 (cyc_q == mite_pkg::CY_TABLE));
      if (ph_end && (cyc_q == mite_pkg::CY_TABLE)) begin
        dm_wdata_q <= prog_data_in[7:0];
      end else if (commit) begin
        dm_wdata_q <= wdata;
      end
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign prog_addr_out   = pm_addr_q;
  assign data_addr_out   = dm_addr_q;
  assign data_wr_out     = dm_wdata_q;
  assign data_we_out     = dm_we_q;
  assign power_down_out  = halt_q;
  assign cycle_start_out = start_q;
  assign working_out     = working_q;
  assign flags_out       = flags_q;
  assign table_high_out  = tbl_hi_q;

endmodule // mite_core

// *** mite_pkg.sv ***
package mite_pkg;

  // ********************************************************************
  // Widths
  // ********************************************************************
  localparam int PC_W = 10;
  localparam int DA_W = 7;
  localparam int IW   = 16;
  localparam int DW   = 8;
  localparam int SD   = 4;
  localparam int SP_W = 2;
  localparam int PH_W = 2;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int              CYC_CLKS = 4;
  localparam logic [PH_W-1:0] PH_LAST  = 2'h3;
  localparam logic [PH_W-1:0] PH_ADDR  = 2'h0;
  localparam logic [PH_W-1:0] PH_READ  = 2'h2;

  // ********************************************************************
  // Reset values and fixed addresses
  // ********************************************************************
  localparam logic [PC_W-1:0] PC_RST      = 10'h000;
  localparam logic [DW-1:0]   WORK_RST    = 8'h00;
  localparam logic [3:0]      FLAGS_RST   = 4'h0;
  localparam logic [DA_W-1:0] PC_LOW_ADDR = 7'h02;
  localparam logic [1:0]      TBL_PAGE    = 2'h3;

  // ********************************************************************
  // Flag positions
  // ********************************************************************
  localparam int F_Z  = 0;
  localparam int F_C  = 1;
  localparam int F_AC = 2;
  localparam int F_OV = 3;

  // ********************************************************************
  // Instruction fields
  // ********************************************************************
  localparam int B_CTL = 15;
  localparam int B_DST = 14;
  localparam int B_IMM = 13;
  localparam int B_TOW = 9;

  // ********************************************************************
  // Operation codes
  // ********************************************************************
  localparam logic [3:0] FN_ADD  = 4'h0;
  localparam logic [3:0] FN_ADC  = 4'h1;
  localparam logic [3:0] FN_SUB  = 4'h2;
  localparam logic [3:0] FN_SBC  = 4'h3;
  localparam logic [3:0] FN_AND  = 4'h4;
  localparam logic [3:0] FN_OR   = 4'h5;
  localparam logic [3:0] FN_XOR  = 4'h6;
  localparam logic [3:0] FN_PASA = 4'h7;
  localparam logic [3:0] FN_PASB = 4'h8;
  localparam logic [3:0] FN_INV  = 4'h9;
  localparam logic [3:0] FN_ADD1 = 4'hA;
  localparam logic [3:0] FN_SUB1 = 4'hB;
  localparam logic [3:0] FN_ROR  = 4'hC;
  localparam logic [3:0] FN_ROL  = 4'hD;
  localparam logic [3:0] FN_RORC = 4'hE;
  localparam logic [3:0] FN_ROLC = 4'hF;

  localparam logic [2:0] K_JUMP  = 3'h0;
  localparam logic [2:0] K_CALL  = 3'h1;
  localparam logic [2:0] K_SEXIT = 3'h2;
  localparam logic [2:0] K_IEXIT = 3'h3;
  localparam logic [2:0] K_BIT   = 3'h4;
  localparam logic [2:0] K_SKZ   = 3'h5;
  localparam logic [2:0] K_TAB   = 3'h6;
  localparam logic [2:0] K_HALT  = 3'h7;

  localparam logic [1:0] BO_CLR = 2'h0;
  localparam logic [1:0] BO_SET = 2'h1;
  localparam logic [1:0] BO_SZ  = 2'h2;
  localparam logic [1:0] BO_SNZ = 2'h3;
  localparam logic [1:0] SK_Z   = 2'h0;
  localparam logic [1:0] SK_IZ  = 2'h1;
  localparam logic [1:0] SK_DZ  = 2'h2;

  typedef enum logic [1:0] {CY_EXEC, CY_BUBBLE, CY_TABLE} mite_cyc_t;

endpackage

// *** mite_alu_if.sv ***
`timescale 1ns/1ps
interface mite_alu_if;
  logic [3:0] func;
  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] res;
  logic       cin;
  logic       z;
  logic       c;
  logic       ac;
  logic       ov;
  logic       upd_z;
  logic       upd_c;
  logic       upd_acov;
  modport core (output func, a, b, cin,
                input res, z, c, ac, ov, upd_z, upd_c, upd_acov);
  modport alu (input func, a, b, cin,
               output res, z, c, ac, ov, upd_z, upd_c, upd_acov);
endinterface

// *** mite_alu.sv ***
`timescale 1ns/1ps
module mite_alu (
  // Operands and results
  mite_alu_if.alu bus
);

  // ********************************************************************
  // Arithmetic, logic and rotate
  // ********************************************************************
  logic [8:0] sum;
  logic [4:0] lo;
  always_comb begin
    logic [7:0] bb;
    logic       ci;
    bb = bus.b;
    ci = 1'b0;
    unique case (bus.func)
      mite_pkg::FN_ADC: ci = bus.cin;
      mite_pkg::FN_SUB: begin
        bb = ~bus.b;
        ci = 1'b1;
      end
      mite_pkg::FN_SBC: begin
        bb = ~bus.b;
        ci = bus.cin;
      end
      default: ci = 1'b0;
    endcase
    sum = {1'b0, bus.a} + {1'b0, bb} + {8'h00, ci};
    lo  = {1'b0, bus.a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
    bus.res      = sum[7:0];
    bus.c        = sum[8];
    bus.ac       = lo[4];
    bus.ov       = (bus.a[7] == bb[7]) && (sum[7] != bus.a[7]);
    bus.upd_z    = 1'b1;
    bus.upd_c    = 1'b1;
    bus.upd_acov = 1'b1;
    unique case (bus.func)
      mite_pkg::FN_ADD, mite_pkg::FN_ADC,
      mite_pkg::FN_SUB, mite_pkg::FN_SBC: bus.res = sum[7:0];
      mite_pkg::FN_AND:  bus.res = bus.a & bus.b;
      mite_pkg::FN_OR:   bus.res = bus.a | bus.b;
      mite_pkg::FN_XOR:  bus.res = bus.a ^ bus.b;
      mite_pkg::FN_PASA: bus.res = bus.a;
      mite_pkg::FN_PASB: bus.res = bus.b;
      mite_pkg::FN_INV:  bus.res = ~bus.b;
      mite_pkg::FN_ADD1: bus.res = bus.b + 8'h01;
      mite_pkg::FN_SUB1: bus.res = bus.b - 8'h01;
      mite_pkg::FN_ROR:  bus.res = {bus.b[0], bus.b[7:1]};
      mite_pkg::FN_ROL:  bus.res = {bus.b[6:0], bus.b[7]};
      mite_pkg::FN_RORC: begin
        bus.res = {bus.cin, bus.b[7:1]};
        bus.c   = bus.b[0];
      end
      mite_pkg::FN_ROLC: begin
        bus.res = {bus.b[6:0], bus.cin};
        bus.c   = bus.b[7];
      end
    endcase
    if (bus.func > mite_pkg::FN_SBC) begin
      bus.upd_acov = 1'b0;
      bus.upd_c    = (bus.func == mite_pkg::FN_RORC) ||
                     (bus.func == mite_pkg::FN_ROLC);
      bus.upd_z    = (bus.func < mite_pkg::FN_PASA) ||
                     (bus.func == mite_pkg::FN_INV) ||
                     (bus.func == mite_pkg::FN_ADD1) ||
                     (bus.func == mite_pkg::FN_SUB1);
    end
    bus.z = (bus.res == 8'h00);
  end

endmodule // mite_alu

// *** mite_core_props.sv ***
`timescale 1ns/1ps
module mite_core_props (
  // Clock and control
  input logic                      ref_clk_in,
  input logic                      sys_rst_in,
  input logic                      clk_en_in,
  input logic                      wake_in,
  // Memories
  input logic [mite_pkg::IW-1:0]   prog_data_in,
  input logic [mite_pkg::PC_W-1:0] prog_addr_out,
  input logic [mite_pkg::DW-1:0]   data_rd_in,
  input logic [mite_pkg::DA_W-1:0] data_addr_out,
  input logic [mite_pkg::DW-1:0]   data_wr_out,
  input logic                      data_we_out,
  // Core state
  input logic                      power_down_out,
  input logic                      cycle_start_out,
  input logic [mite_pkg::DW-1:0]   working_out,
  input logic [3:0]                flags_out,
  input logic [mite_pkg::DW-1:0]   table_high_out
);
  // ******
  // Sequences
  // ******
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  sequence s_run3;
    (clk_en_in && !power_down_out) [*3];
  endsequence
  sequence s_wake4;
    (wake_in && clk_en_in) [*4];
  endsequence
  // ******
  // Checks
  // ******
  a_cycle_period: assert property (
    cycle_start_out && clk_en_in && !power_down_out ##1 s_run3
    |=> cycle_start_out || power_down_out)
    else $error("cycle start missing after four clocks");
  a_cycle_gap: assert property (
    cycle_start_out && clk_en_in |=> (!cycle_start_out) [*3])
    else $error("cycle start too early");
  a_commit_phase: assert property (
    !$past(sys_rst_in) && ($changed(flags_out) || $changed(working_out))
    |-> cycle_start_out)
    else $error("state changed outside cycle start");
  a_write_phase: assert property (
    data_we_out |-> cycle_start_out)
    else $error("write strobe outside phase zero");
  a_write_pulse: assert property (
    data_we_out && clk_en_in |=> !data_we_out)
    else $error("write strobe longer than one clock");
  a_addr_hold: assert property (
    !cycle_start_out && !$past(cycle_start_out)
    |-> $stable(prog_addr_out) && $stable(data_addr_out))
    else $error("address moved inside a cycle");
  a_stall_hold: assert property (
    !clk_en_in |=> $stable(working_out) && $stable(flags_out)
    && $stable(prog_addr_out) && $stable(data_we_out))
    else $error("state moved while stalled");
  a_halt_quiet: assert property (
    power_down_out |-> !cycle_start_out && !data_we_out)
    else $error("activity while powered down");
  a_wake_exit: assert property (
    power_down_out ##0 s_wake4 |-> !power_down_out)
    else $error("no exit from power down");
endmodule // mite_core_props

bind mite_core mite_core_props u_props (
  .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
  .clk_en_in(clk_en_in), .wake_in(wake_in),
  .prog_data_in(prog_data_in), .prog_addr_out(prog_addr_out),
  .data_rd_in(data_rd_in), .data_addr_out(data_addr_out),
  .data_wr_out(data_wr_out), .data_we_out(data_we_out),
  .power_down_out(power_down_out), .cycle_start_out(cycle_start_out),
  .working_out(working_out), .flags_out(flags_out),
  .table_high_out(table_high_out)
);

// *** mite_core_test.sv ***
`timescale 1ns/1ps
module mite_core_test;
  // ******
  // Signals and memories
  // ******
  logic                      ref_clk_in = 1'b0;
  logic                      sys_rst_in = 1'b1;
  logic                      clk_en_in = 1'b1;
  logic                      wake_in = 1'b0;
  logic [mite_pkg::IW-1:0]   prog_data_in = '0;
  logic [mite_pkg::DW-1:0]   data_rd_in = '0;
  logic [mite_pkg::PC_W-1:0] prog_addr_out;
  logic [mite_pkg::DA_W-1:0] data_addr_out;
  logic [mite_pkg::DW-1:0]   data_wr_out;
  logic [mite_pkg::DW-1:0]   working_out;
  logic [mite_pkg::DW-1:0]   table_high_out;
  logic                      data_we_out;
  logic                      power_down_out;
  logic                      cycle_start_out;
  logic [3:0]                flags_out;
  logic [15:0]               prog [0:1023];
  logic [7:0]                dmem [0:127];
  logic [9:0]                tq[$];
  logic [9:0]                exq[$];
  logic [9:0]                last_a;
  int                        tt[$];
  int                        n_errors = 0;
  int                        comparisons = 0;
  int                        cyc = 0;

  mite_core dut (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in), .prog_data_in(prog_data_in),
    .prog_addr_out(prog_addr_out), .data_rd_in(data_rd_in),
    .data_addr_out(data_addr_out), .data_wr_out(data_wr_out),
    .data_we_out(data_we_out), .wake_in(wake_in),
    .power_down_out(power_down_out), .cycle_start_out(cycle_start_out),
    .working_out(working_out), .flags_out(flags_out),
    .table_high_out(table_high_out)
  );

  always #5 ref_clk_in = ~ref_clk_in;

  // Memories and fetch trace below the table area
  always @(posedge ref_clk_in) begin
    prog_data_in <= prog[prog_addr_out];
    data_rd_in <= dmem[data_addr_out];
    if (data_we_out === 1'b1) begin
      dmem[data_addr_out] <= data_wr_out;
    end
    last_a <= prog_addr_out;
    if (!sys_rst_in && prog_addr_out !== last_a
        && prog_addr_out < 10'h300) begin
      tq.push_back(prog_addr_out);
      tt.push_back(cyc);
    end
  end

  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      end_of_test;
    end
  end

  // ******
  // Helpers
  // ******
  function automatic logic [15:0] alu(input logic d, input logic i,
                                      input logic [3:0] f,
                                      input logic [7:0] v);
    return {1'b0, d, i, f, 1'b0, v};
  endfunction

  function automatic logic [15:0] ctl(input logic [2:0] k,
                                      input logic [11:0] v);
    return {1'b1, k, v};
  endfunction

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic boot();
    for (int i = 0; i < 1024; i++) begin
      prog[i] = alu(1'b0, 1'b1, mite_pkg::FN_PASB, 8'hAA);
    end
    for (int i = 0; i < 128; i++) begin
      dmem[i] = 8'h00;
    end
  endtask

  task automatic start();
    @(posedge ref_clk_in);
    sys_rst_in <= 1'b1;
    repeat (20) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    tq.delete();
    tt.delete();
  endtask

  task automatic wait_halt();
    int k;
    k = 0;
    while (power_down_out !== 1'b1 && k < 400) begin
      @(posedge ref_clk_in);
      k++;
    end
    chk("power down", 16'h1, 16'(power_down_out));
  endtask

  task automatic chk_trace();
    chk("trace length", 16'(exq.size()), 16'(tq.size()));
    for (int i = 0; i < exq.size() && i < tq.size(); i++) begin
      chk("fetch address", 16'(exq[i]), 16'(tq[i]));
    end
  endtask

  // ******
  // Scenarios
  // ******
  task automatic t_flow();
    int k;
    boot();
    prog[0] = alu(1'b0, 1'b1, mite_pkg::FN_PASB, 8'hFF);
    prog[1] = alu(1'b0, 1'b1, mite_pkg::FN_ADD, 8'h01);
    prog[2] = ctl(mite_pkg::K_JUMP, 12'h010);
    prog['h10] = ctl(mite_pkg::K_CALL, 12'h020);
    prog['h20] = ctl(mite_pkg::K_CALL, 12'h030);
    prog['h30] = ctl(mite_pkg::K_IEXIT, 12'h000);
    prog['h21] = ctl(mite_pkg::K_SEXIT, 12'h000);
    prog['h11] = ctl(mite_pkg::K_HALT, 12'h000);
    start();
    wait_halt();
    exq = '{1, 2, 3, 'h10, 'h11, 'h20, 'h21, 'h30, 'h31, 'h21, 'h22,
            'h11, 'h12};
    chk_trace();
    for (int i = 1; i < tt.size(); i++) begin
      chk("cycle clocks", 16'(mite_pkg::CYC_CLKS),
          16'(tt[i] - tt[i-1]));
    end
    chk("working", 16'h00, 16'(working_out));
    chk("flags", 16'h7, 16'(flags_out));
    wake_in <= 1'b1;
    k = 0;
    while (power_down_out === 1'b1 && k < 12) begin
      @(posedge ref_clk_in);
      k++;
    end
    chk("wake", 16'h0, 16'(power_down_out));
    wake_in <= 1'b0;
  endtask

  task automatic t_data();
    boot();
    dmem['h11] = 8'hA0;
    dmem['h12] = 8'hFF;
    prog[0] = alu(1'b0, 1'b1, mite_pkg::FN_PASB, 8'h81);
    prog[1] = alu(1'b1, 1'b0, mite_pkg::FN_PASA, 8'h10);
    prog[2] = alu(1'b0, 1'b0, mite_pkg::FN_ROLC, 8'h10);
    prog[3] = ctl(mite_pkg::K_BIT, {mite_pkg::BO_SET, 3'h3, 7'h11});
    prog[4] = ctl(mite_pkg::K_SKZ, {2'h1, 1'b0, 2'h0, 7'h12});
    prog[5] = alu(1'b0, 1'b1, mite_pkg::FN_PASB, 8'h55);
    prog[6] = ctl(mite_pkg::K_BIT, {mite_pkg::BO_SNZ, 3'h0, 7'h13});
    prog[7] = alu(1'b0, 1'b1, mite_pkg::FN_SUB, 8'h03);
    prog[8] = alu(1'b0, 1'b1, mite_pkg::FN_XOR, 8'hFF);
    prog[9] = ctl(mite_pkg::K_TAB, {5'h00, 7'h14});
    prog['hA] = alu(1'b0, 1'b1, mite_pkg::FN_PASB, 8'h40);
    prog['hB] = alu(1'b1, 1'b0, mite_pkg::FN_PASA, 8'h02);
    prog['h40] = ctl(mite_pkg::K_HALT, 12'h000);
    prog['h300] = 16'hBEEF;
    start();
    repeat (30) @(posedge ref_clk_in);
    clk_en_in <= 1'b0;
    repeat (6) @(posedge ref_clk_in);
    clk_en_in <= 1'b1;
    wait_halt();
    exq = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 'hA, 'hB, 'hC, 'h40, 'h41};
    chk_trace();
    chk("mem 10", 16'h81, 16'(dmem['h10]));
    chk("mem 11", 16'hA8, 16'(dmem['h11]));
    chk("mem 12", 16'h00, 16'(dmem['h12]));
    chk("mem 13", 16'h00, 16'(dmem['h13]));
    chk("mem 14", 16'hEF, 16'(dmem['h14]));
    chk("table high", 16'hBE, 16'(table_high_out));
    chk("working", 16'h40, 16'(working_out));
    chk("carry zero", 16'h1, 16'({flags_out[mite_pkg::F_C],
        flags_out[mite_pkg::F_Z]}));
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    t_flow();
    t_data();
    end_of_test();
  end
endmodule // mite_core_test
